// File: rtl/nus_page_store.sv
`timescale 1ns/1ps
`include "nus_regs.svh"

module nus_page_store
    import nus_pkg::*;
(
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_ce,
    input  wire logic                        i_wr_en,
    input  wire nus_page_idx_t               i_wr_page,
    input  wire nus_page_t                   i_wr_data,
    input  wire logic                        i_rd_en,
    input  wire logic [`NUS_ADDR_W-1:0]      i_rd_addr,
    output nus_byte_t                        o_rd_byte
);

    nus_page_t mem [`NUS_PAGES];
    nus_page_idx_t               rd_page;
    logic [`NUS_BYTE_SEL_W-1:0]  rd_sel;

    assign rd_page = i_rd_addr[`NUS_PAGE_SEL_HI:`NUS_PAGE_SEL_LO];
    assign rd_sel  = i_rd_addr[`NUS_BYTE_SEL_HI:`NUS_BYTE_SEL_LO];

    ////////////////////////////////////////////////////////////////////////
    // Page cells: no reset, contents survive it as a nonvolatile store would
    genvar p;
    generate
        for (p = 0; p < `NUS_PAGES; p++) begin : g_page
            always_ff @(posedge i_clk_sys) begin
                if (i_ce && i_wr_en && i_wr_page == nus_page_idx_t'(p)) begin
                    mem[p] <= i_wr_data;
                end
            end
            other_pages_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
                i_wr_en && i_ce && i_wr_page != nus_page_idx_t'(p) |=> $stable(mem[p]))
                else $error("page changed by a write aimed elsewhere");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Byte pick, one clock after the request
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rd_byte <= '0;
        end else if (i_ce && i_rd_en) begin
            o_rd_byte <= mem[rd_page][rd_sel*`NUS_BYTE_W +: `NUS_BYTE_W];
        end
    end

    byte_pick_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && i_rd_en |=> o_rd_byte ==
            $past(mem[rd_page][rd_sel*`NUS_BYTE_W +: `NUS_BYTE_W]))
        else $error("read byte does not match addressed cell");

endmodule

// File: rtl/nus_pkg.sv
package nus_pkg;
    typedef logic [7:0]   nus_byte_t;
    typedef logic [127:0] nus_page_t;
    typedef logic [2:0]   nus_page_idx_t;
    typedef enum logic [2:0] {
        NUS_IDLE,
        NUS_PWR_DN,
        NUS_DECRYPT,
        NUS_WRITE,
        NUS_PWR_UP
    } nus_state_e;
endpackage

// File: rtl/nus_regs.svh
`ifndef NUS_REGS_SVH
`define NUS_REGS_SVH

// Store geometry
`define NUS_PAGES        8
`define NUS_PAGE_W       3
`define NUS_PAGE_BITS    128
`define NUS_BYTE_W       8
`define NUS_BYTE_SEL_W   4
`define NUS_ADDR_W       7
`define NUS_PAGE_SEL_HI  6
`define NUS_PAGE_SEL_LO  4
`define NUS_BYTE_SEL_HI  3
`define NUS_BYTE_SEL_LO  0

// Serial programming frame: data, then page, then encryption flag
`define NUS_FRAME_W      132
`define NUS_FRAME_DATA_LO 0
`define NUS_FRAME_PAGE_LO 128
`define NUS_FRAME_ENC    131

// Test-port pin synchroniser lanes
`define NUS_PIN_N        5
`define NUS_PIN_TCK      0
`define NUS_PIN_TDI      1
`define NUS_PIN_SHIFT    2
`define NUS_PIN_UPDATE   3
`define NUS_PIN_SEL      4

// Timing: times in their own units, cycles derived from the clock rate
`define NUS_CLK_MHZ      40
`define NUS_SETTLE_NS    1000
`define NUS_SETTLE_CYC   ((`NUS_SETTLE_NS * `NUS_CLK_MHZ + 999) / 1000)
`define NUS_PROG_US      100
`define NUS_PROG_CYC     (`NUS_PROG_US * `NUS_CLK_MHZ)
`define NUS_CNT_W        12
`define NUS_CNT_ONE      12'h001
`define NUS_CNT_ZERO     12'h000

`endif

// File: rtl/nus_user_store.sv
`timescale 1ns/1ps
`include "nus_regs.svh"

// How it works
// - The store holds 1 kbit as eight independent pages of 128 bits each.
// - Core logic can read the store during normal operation.
// - Each page is programmed alone, and its data may arrive AES-128 encrypted or plain.
// - Only the boundary-scan test port can write the store; the core has no write path.
// - While a page is programmed the core is held powered down by this controller.

module nus_user_store
    import nus_pkg::*;
(
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_ce,
    // Core read port
    input  wire logic                        i_rd_en,
    input  wire logic [`NUS_ADDR_W-1:0]      i_rd_addr,
    output nus_byte_t                        o_rd_data,
    output logic                             o_rd_valid,
    // Boundary-scan test port pins (asynchronous)
    input  wire logic                        i_tap_tck,
    input  wire logic                        i_tap_tdi,
    input  wire logic                        i_tap_shift,
    input  wire logic                        i_tap_update,
    input  wire logic                        i_tap_prog_sel,
    // Block decrypt engine handshake
    output logic                             o_aes_req,
    output nus_page_t                        o_aes_cipher,
    input  wire logic                        i_aes_done,
    input  wire nus_page_t                   i_aes_plain,
    // Status
    output logic                             o_core_pwr_dn,
    output logic                             o_prog_busy
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage one feeds stage two and nothing else
    logic [`NUS_PIN_N-1:0] pin_raw;
    logic [`NUS_PIN_N-1:0] pin_m;
    logic [`NUS_PIN_N-1:0] pin_s;
    logic [`NUS_PIN_N-1:0] pin_d;

    assign pin_raw[`NUS_PIN_TCK]    = i_tap_tck;
    assign pin_raw[`NUS_PIN_TDI]    = i_tap_tdi;
    assign pin_raw[`NUS_PIN_SHIFT]  = i_tap_shift;
    assign pin_raw[`NUS_PIN_UPDATE] = i_tap_update;
    assign pin_raw[`NUS_PIN_SEL]    = i_tap_prog_sel;

    genvar b;
    generate
        for (b = 0; b < `NUS_PIN_N; b++) begin : g_sync
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    pin_m[b] <= 1'b0;
                    pin_s[b] <= 1'b0;
                    pin_d[b] <= 1'b0;
                end else if (i_ce) begin
                    pin_m[b] <= pin_raw[b];
                    pin_s[b] <= pin_m[b];
                    pin_d[b] <= pin_s[b];                    // Edge history only
                end
            end
        end
    endgenerate

    logic tck_rise;
    logic upd_rise;
    assign tck_rise = pin_s[`NUS_PIN_TCK] & ~pin_d[`NUS_PIN_TCK];
    assign upd_rise = pin_s[`NUS_PIN_UPDATE] & ~pin_d[`NUS_PIN_UPDATE];

    ////////////////////////////////////////////////////////////////////////
    // Serial frame shifted in LSB first on each test clock rise while shift is high
    logic [`NUS_FRAME_W-1:0] frame;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            frame <= '0;
        end else if (i_ce && tck_rise && pin_s[`NUS_PIN_SHIFT]) begin
            frame <= {pin_s[`NUS_PIN_TDI], frame[`NUS_FRAME_W-1:1]};
        end
    end

    // Only an update with the programming instruction selected starts a write
    logic go;
    assign go = upd_rise & pin_s[`NUS_PIN_SEL];

    ////////////////////////////////////////////////////////////////////////
    // Programming sequencer
    nus_state_e               state;
    nus_state_e               next_state;
    logic [`NUS_CNT_W-1:0]    cnt;
    logic                     cnt_done;
    logic                     enc_flag;
    nus_page_idx_t            wr_page;
    nus_page_t                wr_data;
    logic                     wr_en;

    assign cnt_done = (cnt == `NUS_CNT_ZERO);

    // Next state; new frames are ignored until the sequence is back in idle
    always_comb begin
        next_state = state;
        case (state)
            NUS_IDLE: begin
                if (go) begin
                    next_state = NUS_PWR_DN;
                end
            end
            NUS_PWR_DN: begin
                if (cnt_done) begin
                    next_state = enc_flag ? NUS_DECRYPT : NUS_WRITE;
                end
            end
            NUS_DECRYPT: begin
                if (i_aes_done) begin
                    next_state = NUS_WRITE;
                end
            end
            NUS_WRITE: begin
                if (cnt_done) begin
                    next_state = NUS_PWR_UP;
                end
            end
            NUS_PWR_UP: begin
                if (cnt_done) begin
                    next_state = NUS_IDLE;
                end
            end
            default: begin
                next_state = NUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= NUS_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // Wait counter, reloaded on each entry to a timed state
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cnt <= `NUS_CNT_ZERO;
        end else if (i_ce) begin
            if (state != next_state && next_state == NUS_WRITE) begin
                cnt <= `NUS_CNT_W'(`NUS_PROG_CYC - 1);
            end else if (state != next_state && (next_state == NUS_PWR_DN ||
                                                 next_state == NUS_PWR_UP)) begin
                cnt <= `NUS_CNT_W'(`NUS_SETTLE_CYC - 1);
            end else if (!cnt_done) begin
                cnt <= cnt - `NUS_CNT_ONE;
            end
        end
    end

    // Frame capture at start; decrypted text replaces cipher text on return
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            enc_flag <= 1'b0;
            wr_page  <= '0;
            wr_data  <= '0;
        end else if (i_ce) begin
            if (state == NUS_IDLE && go) begin
                enc_flag <= frame[`NUS_FRAME_ENC];
                wr_page  <= frame[`NUS_FRAME_PAGE_LO +: `NUS_PAGE_W];
                wr_data  <= frame[`NUS_FRAME_DATA_LO +: `NUS_PAGE_BITS];
            end else if (state == NUS_DECRYPT && i_aes_done) begin
                wr_data  <= i_aes_plain;
            end
        end
    end

    // Cipher block held steady for the engine while it works
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_aes_cipher <= '0;
        end else if (i_ce && state == NUS_IDLE && go) begin
            o_aes_cipher <= frame[`NUS_FRAME_DATA_LO +: `NUS_PAGE_BITS];
        end
    end

    assign o_aes_req = (state == NUS_DECRYPT);

    // One write pulse at the end of the programming time, core already down
    assign wr_en = (state == NUS_WRITE) && cnt_done;

    // Core held down from the start until the power-up settle ends
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_core_pwr_dn <= 1'b0;
        end else if (i_ce) begin
            o_core_pwr_dn <= (next_state != NUS_IDLE);
        end
    end

    assign o_prog_busy = (state != NUS_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Core read path; a powered-down core gets no answer
    logic rd_take;
    assign rd_take = i_rd_en & ~o_core_pwr_dn;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= rd_take;
        end
    end

    nus_page_store u_store (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_wr_en   (wr_en),
        .i_wr_page (wr_page),
        .i_wr_data (wr_data),
        .i_rd_en   (rd_take),
        .i_rd_addr (i_rd_addr),
        .o_rd_byte (o_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_start;
        state == NUS_IDLE && go && i_ce;
    endsequence

    sequence s_held_down;
        o_core_pwr_dn [*8];
    endsequence

    sequence s_decrypt_back;
        state == NUS_DECRYPT && i_aes_done && i_ce;
    endsequence

    read_answer_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && i_rd_en && !o_core_pwr_dn |=> o_rd_valid)
        else $error("core read not answered next cycle");

    no_read_down_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce && o_core_pwr_dn |=> !o_rd_valid)
        else $error("read answered while core powered down");

    plain_text_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_decrypt_back |=> wr_data == $past(i_aes_plain) && state == NUS_WRITE)
        else $error("decrypted page not taken");

    enc_route_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state == NUS_DECRYPT |-> enc_flag && o_aes_req)
        else $error("decrypt entered for a plain page");

    port_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_en |-> state == NUS_WRITE && o_prog_busy && !rd_take)
        else $error("store written outside the programming sequence");

    core_down_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_start |=> s_held_down)
        else $error("core not held down after programming start");

    write_down_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_en |-> o_core_pwr_dn)
        else $error("page written with core powered");

endmodule

// File: tb/nus_core_reader.sv
`timescale 1ns/1ps
`include "nus_regs.svh"

// Core-fabric user logic: on a go pulse it reads all 16 bytes of one page
// back to back and gathers whatever answers come back, in order.
module nus_core_reader
    import nus_pkg::*;
(
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_go,
    input  wire nus_page_idx_t          i_page,
    output logic                        o_rd_en,
    output logic [`NUS_ADDR_W-1:0]      o_rd_addr,
    input  wire nus_byte_t              i_rd_data,
    input  wire logic                   i_rd_valid,
    output nus_page_t                   o_page,
    output logic [4:0]                  o_cnt,
    output logic                        o_run
);
    logic [4:0] idx;

    initial begin
        o_rd_en   = 1'b0;
        o_rd_addr = 7'h00;
        o_run     = 1'b0;
        idx       = 5'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Request side moves on the falling edge; once idle the address is
    // inverted so a stale value never looks like a held request
    always @(negedge i_clk_sys) begin
        if (i_go && !o_run) begin
            o_run <= 1'b1;
            idx   <= 5'h00;
        end else if (o_run) begin
            if (idx < 5'h10) begin
                o_rd_en   <= 1'b1;
                o_rd_addr <= {i_page, idx[3:0]}; // Page high, byte low
                idx       <= idx + 5'h01;
            end else if (idx == 5'h10) begin
                o_rd_en   <= 1'b0;
                o_rd_addr <= ~o_rd_addr;
                idx       <= 5'h11;
            end else begin
                o_run <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answers are stored by arrival order, which equals byte order
    always @(posedge i_clk_sys) begin
        if (i_go) begin
            o_cnt <= 5'h00;
        end else if (i_rd_valid === 1'b1) begin
            o_page[8*o_cnt[3:0] +: 8] <= i_rd_data;
            o_cnt                     <= o_cnt + 5'h01;
        end
    end
endmodule

// File: tb/test_nus_user_store.sv
`timescale 1ns/1ps
`include "nus_regs.svh"

module test_nus_user_store
    import nus_pkg::*;
;
    localparam nus_page_t KEY = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    localparam nus_page_t D2  = 128'h00112233445566778899aabbccddeeff;
    localparam nus_page_t D5  = 128'hdeadbeef0123456789abcdeffedcba98;
    logic                    i_clk_sys, i_rst_n, i_ce, rd_en, rd_valid, go, rd_run;
    logic                    tck, tdi, shift, upd, sel, aes_req, aes_done, pwr_dn, busy;
    logic [`NUS_ADDR_W-1:0]  rd_addr;
    nus_byte_t               rd_data;
    nus_page_t               aes_cipher, aes_plain, got_page;
    nus_page_idx_t           rd_page;
    logic [4:0]              got_cnt;
    int                      fails, checks_done, cycles, aes_wait;

    nus_user_store u_nus_user_store (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .i_tap_tck(tck), .i_tap_tdi(tdi), .i_tap_shift(shift), .i_tap_update(upd),
        .i_tap_prog_sel(sel), .o_aes_req(aes_req), .o_aes_cipher(aes_cipher),
        .i_aes_done(aes_done), .i_aes_plain(aes_plain), .o_core_pwr_dn(pwr_dn),
        .o_prog_busy(busy));
    nus_core_reader u_nus_core_reader (.i_clk_sys(i_clk_sys), .i_go(go), .i_page(rd_page),
        .o_rd_en(rd_en), .o_rd_addr(rd_addr), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .o_page(got_page), .o_cnt(got_cnt), .o_run(rd_run));

    ////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and a slow decrypt engine (answers after 20 cycles)
    always #12.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            complete_run();
        end
    end
    always @(negedge i_clk_sys) begin
        aes_done <= 1'b0;
        aes_wait <= (aes_req === 1'b1) ? aes_wait + 1 : 0;
        if (aes_req === 1'b1 && aes_wait == 20) begin
            aes_done  <= 1'b1;
            aes_plain <= aes_cipher ^ KEY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check_val(input nus_page_t got, input nus_page_t exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Frame goes out LSB first; tck is held 4 cycles per level
    task automatic send_frame(input logic enc, input nus_page_idx_t pg, input nus_page_t d);
        logic [`NUS_FRAME_W-1:0] f;
        f = {enc, pg, d};
        for (int i = 0; i < `NUS_FRAME_W; i++) begin
            tdi   = f[i];
            shift = 1'b1;
            repeat (4) @(negedge i_clk_sys);
            tck = 1'b1;
            repeat (4) @(negedge i_clk_sys);
            tck = 1'b0;
        end
        shift = 1'b0;
        upd   = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        upd = 1'b0;
    endtask

    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim && busy !== lvl; n++) @(negedge i_clk_sys);
        check_val(busy, lvl, "busy level");
    endtask

    task automatic read_page(input nus_page_idx_t pg);
        rd_page = pg;
        go <= 1'b1;
        @(negedge i_clk_sys);
        go <= 1'b0;
        @(negedge i_clk_sys);
        for (int n = 0; n < 40 && rd_run; n++) @(negedge i_clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check_val(pwr_dn, 1'b0, "pwr_dn after reset");
        check_val(rd_valid, 1'b0, "valid after reset");
        check_val(rd_data, 8'h00, "data after reset");
        $display("test_reset done");
    endtask

    // Plain page write, a second frame during busy is ignored, full readback
    task automatic test_plain();
        send_frame(1'b0, 3'h2, D2);
        wait_busy(1'b1, 10);
        check_val(pwr_dn, 1'b1, "core held down");
        send_frame(1'b0, 3'h6, ~D2);
        wait_busy(1'b0, 5000);
        repeat (10) @(negedge i_clk_sys);
        check_val(busy, 1'b0, "update during busy ignored");
        read_page(3'h2);
        check_val(got_cnt, 5'h10, "sixteen answers");
        check_val(got_page, D2, "page 2 bytes");
        $display("test_plain done");
    endtask

    // Update without the select starts nothing; encrypted write; reads refused while down
    task automatic test_enc();
        sel = 1'b0;
        send_frame(1'b0, 3'h2, ~D2);
        repeat (10) @(negedge i_clk_sys);
        check_val(busy, 1'b0, "update without select ignored");
        sel = 1'b1;
        send_frame(1'b1, 3'h5, D5 ^ KEY);
        for (int n = 0; n < 100 && aes_req !== 1'b1; n++) @(negedge i_clk_sys);
        check_val(aes_cipher, D5 ^ KEY, "cipher to engine");
        check_val(pwr_dn, 1'b1, "down before decrypt");
        read_page(3'h2);
        check_val(got_cnt, 5'h00, "reads refused");
        check_val(rd_data, D2[127:120], "data held");
        wait_busy(1'b0, 5000);
        check_val(pwr_dn, 1'b0, "core back up");
        read_page(3'h5);
        check_val(got_page, D5, "page 5 decrypted");
        read_page(3'h2);
        check_val(got_page, D2, "page 2 untouched");
        // Clock enable low freezes the read path: no answer, data held
        i_ce = 1'b0;
        read_page(3'h5);
        check_val(got_cnt, 5'h00, "no answers while frozen");
        check_val(rd_data, D2[127:120], "data frozen");
        i_ce = 1'b1;
        $display("test_enc done");
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; i_ce stays high except in the frozen-read step
    initial begin
        {i_clk_sys, i_rst_n, tck, tdi, shift, upd, go} = '0;
        {i_ce, sel} = 2'b11;
        rd_page     = 3'h0;
        repeat (4) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        test_reset();
        test_plain();
        test_enc();
        complete_run();
    end
endmodule
